/* src/pcd_top.sv */
// pin change detector: per-pin edge flags, master enable, wake and interrupt
//
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns

// one port: synchroniser, edge detect, enables and flags
module pcd_port
    import pcd_pkg::*;
#(
    parameter int WIDTH = PCD_DATA_W,
    parameter logic [PCD_DATA_W-1:0] MASK = PCD_FULL_MASK
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_pins,
    input wire logic i_wr_rise,
    input wire logic i_wr_fall,
    input wire logic i_wr_flag,
    input wire logic [WIDTH-1:0] i_wdata,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall,
    output logic [WIDTH-1:0] o_flag,
    output logic o_edge
);
    logic [WIDTH-1:0] sync_a;
    logic [WIDTH-1:0] sync_b;
    logic [WIDTH-1:0] prev;
    logic [WIDTH-1:0] next_flag;
    wire [WIDTH-1:0] mask_w = MASK[WIDTH-1:0];
    wire [WIDTH-1:0] rise_hit = sync_b & ~prev & o_rise;
    wire [WIDTH-1:0] fall_hit = ~sync_b & prev & o_fall;
    wire [WIDTH-1:0] hit = (rise_hit | fall_hit) & mask_w;

    // hardware set wins over a software clear in the same cycle
    assign next_flag = (i_wr_flag ? (i_wdata & mask_w) : o_flag) | hit;

    always_ff @(posedge i_sys_clk) begin
        sync_a <= i_pins;
        sync_b <= sync_a;
        prev <= sync_b;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rise <= '0;
            o_fall <= '0;
            o_flag <= '0;
            o_edge <= 1'b0;
        end else begin
            if (i_wr_rise) begin
                o_rise <= i_wdata & mask_w;
            end
            if (i_wr_fall) begin
                o_fall <= i_wdata & mask_w;
            end
            o_flag <= next_flag;
            o_edge <= |hit;
        end
    end

    a_flag_set_on_hit: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (hit != '0) |=> ((o_flag & $past(hit)) == $past(hit)))
        else $error("detected edge did not set its flag");
    a_flag_clear_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_wr_flag && hit == '0) |=> (o_flag == ($past(i_wdata) & mask_w)))
        else $error("flag write not stored");
    a_flag_no_spur: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_wr_flag && hit == '0) |=> $stable(o_flag))
        else $error("flag changed without cause");
    a_rise_gated: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_rise == '0 && o_fall == '0) |-> (hit == '0))
        else $error("edge flagged with detectors off");
    a_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ((o_flag | o_rise | o_fall) & ~mask_w) == '0)
        else $error("unimplemented bit set");

    // no disable here, so the cycle right after release is looked at too
    a_port_reset_zero: assert property (@(posedge i_sys_clk)
        $past(i_rst) |-> (o_rise == '0 && o_fall == '0 && o_flag == '0))
        else $error("port register not zero after reset");
    a_rise_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_wr_rise |=> (o_rise == ($past(i_wdata) & mask_w)))
        else $error("rise enable write not stored");
    a_fall_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_wr_fall |=> (o_fall == ($past(i_wdata) & mask_w)))
        else $error("fall enable write not stored");
    a_enables_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_wr_rise && !i_wr_fall) |=> ($stable(o_rise) && $stable(o_fall)))
        else $error("edge enable changed without a write");
    a_rise_detect: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ((sync_b & ~prev & o_rise & mask_w) != '0)
        |=> ((o_flag & $past(sync_b & ~prev & o_rise & mask_w)) != '0))
        else $error("enabled rising edge not flagged");
    a_fall_detect: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ((~sync_b & prev & o_fall & mask_w) != '0)
        |=> ((o_flag & $past(~sync_b & prev & o_fall & mask_w)) != '0))
        else $error("enabled falling edge not flagged");
    a_both_edges: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        ((o_rise & o_fall & mask_w & (sync_b ^ prev)) != '0) |-> (hit != '0))
        else $error("change missed with both enables set");
    a_edge_marks_flag: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_edge |-> (o_flag != '0))
        else $error("edge reported without a flag");
    a_sync_depth: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (sync_b == $past(i_pins, 2)) && (prev == $past(sync_b)))
        else $error("pin sample pipeline out of step");
endmodule

module pcd_top
    import pcd_pkg::*;
#(
    parameter int PORT_W = PCD_DATA_W
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // register port
    input wire logic [PCD_ADDR_W-1:0] i_addr,
    input wire logic [PCD_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [PCD_DATA_W-1:0] o_rdata,
    // pins
    input wire logic [PORT_W-1:0] i_port_a_pin_n,
    input wire logic [PORT_W-1:0] i_port_b_pin_n,
    input wire logic [PORT_W-1:0] i_port_c_pin_n,
    input wire logic [PORT_W-1:0] i_port_e_pin_n,
    // core side
    input wire logic i_sleep,
    output logic o_change_irq,
    output logic o_wake,
    output logic o_irq
);
    pcd_bus_t bus;
    pcd_port_regs_t ra, rb, rc, re;
    logic [PCD_EV_W-1:0] edges;
    logic master_en;
    logic [PCD_EV_W-1:0] ev_stat;
    logic [PCD_EV_W-1:0] ev_en;
    logic [PCD_EV_W-1:0] next_ev_stat;

    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

    wire sel_ar = bus.wr && bus.addr == PCD_A_RISE;
    wire sel_af = bus.wr && bus.addr == PCD_A_FALL;
    wire sel_ag = bus.wr && bus.addr == PCD_A_FLAG;
    wire sel_br = bus.wr && bus.addr == PCD_B_RISE;
    wire sel_bf = bus.wr && bus.addr == PCD_B_FALL;
    wire sel_bg = bus.wr && bus.addr == PCD_B_FLAG;
    wire sel_cr = bus.wr && bus.addr == PCD_C_RISE;
    wire sel_cf = bus.wr && bus.addr == PCD_C_FALL;
    wire sel_cg = bus.wr && bus.addr == PCD_C_FLAG;
    wire sel_er = bus.wr && bus.addr == PCD_E_RISE;
    wire sel_ef = bus.wr && bus.addr == PCD_E_FALL;
    wire sel_eg = bus.wr && bus.addr == PCD_E_FLAG;
    wire sel_ctrl = bus.wr && bus.addr == PCD_CTRL;
    wire sel_clr = bus.wr && bus.addr == PCD_IRQ_CLR;
    wire sel_en = bus.wr && bus.addr == PCD_IRQ_EN;

    // ports A, B and C use all eight pins; port E keeps only pin 3 through its mask
    pcd_port #(.WIDTH(PORT_W), .MASK(PCD_FULL_MASK)) u_pa (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_port_a_pin_n),
        .i_wr_rise(sel_ar),
        .i_wr_fall(sel_af),
        .i_wr_flag(sel_ag),
        .i_wdata(bus.wdata[PORT_W-1:0]),
        .o_rise(ra.rise),
        .o_fall(ra.fall),
        .o_flag(ra.flag),
        .o_edge(edges[PCD_EV_A_BIT])
    );
    pcd_port #(.WIDTH(PORT_W), .MASK(PCD_FULL_MASK)) u_pb (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_port_b_pin_n),
        .i_wr_rise(sel_br),
        .i_wr_fall(sel_bf),
        .i_wr_flag(sel_bg),
        .i_wdata(bus.wdata[PORT_W-1:0]),
        .o_rise(rb.rise),
        .o_fall(rb.fall),
        .o_flag(rb.flag),
        .o_edge(edges[PCD_EV_B_BIT])
    );
    pcd_port #(.WIDTH(PORT_W), .MASK(PCD_FULL_MASK)) u_pc (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_port_c_pin_n),
        .i_wr_rise(sel_cr),
        .i_wr_fall(sel_cf),
        .i_wr_flag(sel_cg),
        .i_wdata(bus.wdata[PORT_W-1:0]),
        .o_rise(rc.rise),
        .o_fall(rc.fall),
        .o_flag(rc.flag),
        .o_edge(edges[PCD_EV_C_BIT])
    );
    pcd_port #(.WIDTH(PORT_W), .MASK(PCD_E_MASK)) u_pe (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pins(i_port_e_pin_n),
        .i_wr_rise(sel_er),
        .i_wr_fall(sel_ef),
        .i_wr_flag(sel_eg),
        .i_wdata(bus.wdata[PORT_W-1:0]),
        .o_rise(re.rise),
        .o_fall(re.fall),
        .o_flag(re.flag),
        .o_edge(edges[PCD_EV_E_BIT])
    );

    wire summary = |{ra.flag, rb.flag, rc.flag, re.flag};
    // request follows flags, so it also covers flags set while masked
    wire next_change_irq = master_en && summary;
    // wake from any enabled edge while asleep with master enable set; flags already hold it
    wire next_wake = master_en && i_sleep && (edges != '0 || summary);

    // sticky per-port events; set beats clear
    assign next_ev_stat = (sel_clr ? (ev_stat & ~bus.wdata[PCD_EV_W-1:0]) : ev_stat) | edges;

    wire [PCD_DATA_W-1:0] ctrl_rd = (PCD_DATA_W'(master_en) << PCD_CTRL_MASTER_BIT)
        | (PCD_DATA_W'(summary) << PCD_CTRL_SUMMARY_BIT);
    logic [PCD_DATA_W-1:0] next_rdata;

    // read decode; the clear register and unmapped indices read zero
    always_comb begin
        next_rdata = PCD_RD_ZERO;
        if (!bus.rd) begin
            next_rdata = PCD_RD_ZERO;
        end else if (bus.addr == PCD_A_RISE) begin
            next_rdata = PCD_DATA_W'(ra.rise);
        end else if (bus.addr == PCD_A_FALL) begin
            next_rdata = PCD_DATA_W'(ra.fall);
        end else if (bus.addr == PCD_A_FLAG) begin
            next_rdata = PCD_DATA_W'(ra.flag);
        end else if (bus.addr == PCD_B_RISE) begin
            next_rdata = PCD_DATA_W'(rb.rise);
        end else if (bus.addr == PCD_B_FALL) begin
            next_rdata = PCD_DATA_W'(rb.fall);
        end else if (bus.addr == PCD_B_FLAG) begin
            next_rdata = PCD_DATA_W'(rb.flag);
        end else if (bus.addr == PCD_C_RISE) begin
            next_rdata = PCD_DATA_W'(rc.rise);
        end else if (bus.addr == PCD_C_FALL) begin
            next_rdata = PCD_DATA_W'(rc.fall);
        end else if (bus.addr == PCD_C_FLAG) begin
            next_rdata = PCD_DATA_W'(rc.flag);
        end else if (bus.addr == PCD_E_RISE) begin
            next_rdata = PCD_DATA_W'(re.rise);
        end else if (bus.addr == PCD_E_FALL) begin
            next_rdata = PCD_DATA_W'(re.fall);
        end else if (bus.addr == PCD_E_FLAG) begin
            next_rdata = PCD_DATA_W'(re.flag);
        end else if (bus.addr == PCD_CTRL) begin
            next_rdata = ctrl_rd;
        end else if (bus.addr == PCD_IRQ_STAT) begin
            next_rdata = PCD_DATA_W'(ev_stat);
        end else if (bus.addr == PCD_IRQ_EN) begin
            next_rdata = PCD_DATA_W'(ev_en);
        end else begin
            next_rdata = PCD_RD_ZERO;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            master_en <= 1'b0;
            ev_stat <= '0;
            ev_en <= '0;
            o_rdata <= PCD_RST_BYTE;
            o_change_irq <= 1'b0;
            o_wake <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            if (sel_ctrl) begin
                master_en <= bus.wdata[PCD_CTRL_MASTER_BIT];
            end
            if (sel_en) begin
                ev_en <= bus.wdata[PCD_EV_W-1:0];
            end
            ev_stat <= next_ev_stat;
            o_rdata <= next_rdata;
            o_change_irq <= next_change_irq;
            o_wake <= next_wake;
            o_irq <= |(next_ev_stat & (sel_en ? bus.wdata[PCD_EV_W-1:0] : ev_en));
        end
    end

    sequence s_edge_seen;
        edges != '0;
    endsequence
    sequence s_flag_then_req;
        ##1 summary ##1 o_change_irq;
    endsequence
    sequence s_asleep_armed;
        master_en && i_sleep;
    endsequence
    sequence s_read_ctrl;
        bus.rd && bus.addr == PCD_CTRL;
    endsequence

    a_master_gates_req: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !master_en |=> !o_change_irq)
        else $error("request raised with master enable clear");
    a_edge_to_request: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_edge_seen and master_en && !sel_ctrl && !sel_ag && !sel_bg && !sel_cg && !sel_eg)
        |-> s_flag_then_req)
        else $error("enabled edge gave no request");
    a_summary_is_or: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_change_irq |-> $past(summary && master_en))
        else $error("request without a flag");
    a_sleep_wake: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (master_en && i_sleep && summary) |=> o_wake)
        else $error("no wake with flag set in sleep");

    // no disable here, so the cycle right after release is looked at too
    a_top_reset_zero: assert property (@(posedge i_sys_clk)
        $past(i_rst) |-> (!o_change_irq && !o_wake && !o_irq && o_rdata == PCD_RST_BYTE))
        else $error("output not zero after reset");
    a_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_rd |=> (o_rdata == PCD_RD_ZERO))
        else $error("read data shown without a read");
    a_ctrl_readback: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_read_ctrl |=> (o_rdata[PCD_CTRL_SUMMARY_BIT] == $past(summary)
            && o_rdata[PCD_CTRL_MASTER_BIT] == $past(master_en)))
        else $error("control read does not match state");
    a_request_follows: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (master_en && summary) |=> o_change_irq)
        else $error("pending flag gave no request");
    a_request_drops: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !summary |=> !o_change_irq)
        else $error("request held with no flag set");
    a_wake_gated: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !(master_en && i_sleep) |=> !o_wake)
        else $error("wake raised while awake or masked");
    a_wake_on_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_asleep_armed ##0 (edges != '0)) |=> o_wake)
        else $error("edge in sleep gave no wake");
    a_flag_before_wake: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_wake |-> $past(summary))
        else $error("wake without a recorded flag");
    a_master_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_ctrl |=> (master_en == $past(i_wdata[PCD_CTRL_MASTER_BIT])))
        else $error("master enable write not stored");
    a_master_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !sel_ctrl |=> $stable(master_en))
        else $error("master enable changed without a write");
    a_stat_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (edges != '0) |=> ((ev_stat & $past(edges)) == $past(edges)))
        else $error("port event not recorded");
    a_stat_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (sel_clr && edges == '0)
        |=> (ev_stat == ($past(ev_stat) & ~$past(i_wdata[PCD_EV_W-1:0]))))
        else $error("event clear not applied");
    a_en_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sel_en |=> (ev_en == $past(i_wdata[PCD_EV_W-1:0])))
        else $error("event enable write not stored");
    a_irq_level: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_irq == ((ev_stat & ev_en) != '0))
        else $error("interrupt level does not follow events");
endmodule

/* src/pcd_pkg.sv */
// package: register map, field positions and types of the pin change detector
package pcd_pkg;
    localparam int PCD_ADDR_W = 5;
    localparam int PCD_DATA_W = 8;

    // register indices (byte-wide registers, one per address)
    localparam logic [PCD_ADDR_W-1:0] PCD_A_RISE = 5'h00;
    localparam logic [PCD_ADDR_W-1:0] PCD_A_FALL = 5'h01;
    localparam logic [PCD_ADDR_W-1:0] PCD_A_FLAG = 5'h02;
    localparam logic [PCD_ADDR_W-1:0] PCD_B_RISE = 5'h03;
    localparam logic [PCD_ADDR_W-1:0] PCD_B_FALL = 5'h04;
    localparam logic [PCD_ADDR_W-1:0] PCD_B_FLAG = 5'h05;
    localparam logic [PCD_ADDR_W-1:0] PCD_C_RISE = 5'h06;
    localparam logic [PCD_ADDR_W-1:0] PCD_C_FALL = 5'h07;
    localparam logic [PCD_ADDR_W-1:0] PCD_C_FLAG = 5'h08;
    localparam logic [PCD_ADDR_W-1:0] PCD_E_RISE = 5'h09;
    localparam logic [PCD_ADDR_W-1:0] PCD_E_FALL = 5'h0a;
    localparam logic [PCD_ADDR_W-1:0] PCD_E_FLAG = 5'h0b;
    localparam logic [PCD_ADDR_W-1:0] PCD_CTRL = 5'h0c;
    localparam logic [PCD_ADDR_W-1:0] PCD_IRQ_STAT = 5'h0d;
    localparam logic [PCD_ADDR_W-1:0] PCD_IRQ_CLR = 5'h0e;
    localparam logic [PCD_ADDR_W-1:0] PCD_IRQ_EN = 5'h0f;

    // control register fields
    localparam int PCD_CTRL_MASTER_BIT = 0;
    localparam int PCD_CTRL_SUMMARY_BIT = 1;
    // irq status fields: one sticky event bit per port
    localparam int PCD_EV_A_BIT = 0;
    localparam int PCD_EV_B_BIT = 1;
    localparam int PCD_EV_C_BIT = 2;
    localparam int PCD_EV_E_BIT = 3;
    localparam int PCD_EV_W = 4;

    // port E implements only pin 3
    localparam logic [PCD_DATA_W-1:0] PCD_E_MASK = 8'h08;
    localparam logic [PCD_DATA_W-1:0] PCD_FULL_MASK = 8'hff;
    localparam logic [PCD_DATA_W-1:0] PCD_RST_BYTE = 8'h00;
    localparam logic [PCD_DATA_W-1:0] PCD_RD_ZERO = 8'h00;

    typedef struct packed {
        logic [PCD_ADDR_W-1:0] addr;
        logic [PCD_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } pcd_bus_t;

    typedef struct packed {
        logic [PCD_DATA_W-1:0] rise;
        logic [PCD_DATA_W-1:0] fall;
        logic [PCD_DATA_W-1:0] flag;
    } pcd_port_regs_t;
endpackage

/* verif/pcd_pin_model.sv */
// pin level model: the outside world driving the four port pin groups
`timescale 1ns/1ns
module pcd_pin_model (
    // pins
    output logic [7:0] o_port_a,
    output logic [7:0] o_port_b,
    output logic [7:0] o_port_c,
    output logic [7:0] o_port_e
);
    initial begin
        o_port_a = 8'h00;
        o_port_b = 8'h00;
        o_port_c = 8'h00;
        o_port_e = 8'h00;
    end
    // levels move just after a clock edge, so the synchroniser sees a clean step
    task automatic set_levels(input logic [7:0] a, b, c, e);
        o_port_a <= a;
        o_port_b <= b;
        o_port_c <= c;
        o_port_e <= e;
    endtask
endmodule

/* verif/testbench.sv */
// self-checking bench of the pin change detector against a behavioural model
`timescale 1ns/1ns
module testbench;
    import pcd_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [PCD_ADDR_W-1:0] i_addr = '0;
    logic [PCD_DATA_W-1:0] i_wdata = '0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_sleep = 1'b0;
    logic [PCD_DATA_W-1:0] o_rdata;
    logic [7:0] pa, pb, pc, pe;
    logic o_change_irq, o_wake, o_irq;
    logic [7:0] rise [4] = '{default: 8'h00};
    logic [7:0] fall [4] = '{default: 8'h00};
    logic [7:0] flag [4] = '{default: 8'h00};
    logic [7:0] cur [4] = '{default: 8'h00};
    logic [3:0] stat = 4'h0;
    logic [3:0] ev_en = 4'h0;
    logic master = 1'b0;
    logic [31:0] seed = 32'he0f1;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    pcd_pin_model pins (.o_port_a(pa), .o_port_b(pb), .o_port_c(pc), .o_port_e(pe));
    pcd_top dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_port_a_pin_n(pa),
        .i_port_b_pin_n(pb), .i_port_c_pin_n(pc), .i_port_e_pin_n(pe), .i_sleep(i_sleep),
        .o_change_irq(o_change_irq), .o_wake(o_wake), .o_irq(o_irq));
    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // the run needs about 3700 cycles; far beyond that means a hang
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] msk(input int p);
        return (p == 3) ? PCD_E_MASK : PCD_FULL_MASK;
    endfunction
    function automatic logic anyf();
        return |(flag[0] | flag[1] | flag[2] | flag[3]);
    endfunction
    function automatic logic [7:0] exp_rd(input int a);
        int p;
        p = a / 3;
        if (a < 12) return (a % 3 == 0) ? rise[p] : (a % 3 == 1) ? fall[p] : flag[p];
        if (a == PCD_CTRL) return {6'h00, anyf(), master};
        if (a == PCD_IRQ_STAT) return {4'h0, stat};
        if (a == PCD_IRQ_EN) return {4'h0, ev_en};
        return 8'h00;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp, $sformatf("read %h", a));
    endtask
    task automatic mwr(input int a, input logic [7:0] d);
        int p;
        p = a / 3;
        wr(5'(a), d);
        if (a < 12 && a % 3 == 0) rise[p] = d & msk(p);
        else if (a < 12 && a % 3 == 1) fall[p] = d & msk(p);
        else if (a < 12) flag[p] = d & msk(p);
        else if (a == PCD_CTRL) master = d[0];
        else if (a == PCD_IRQ_CLR) stat = stat & ~d[3:0];
        else if (a == PCD_IRQ_EN) ev_en = d[3:0];
    endtask
    task automatic check_all();
        for (int a = 0; a < 32; a++) rd(5'(a), exp_rd(a));
        chk({7'h0, o_change_irq}, {7'h0, master & anyf()}, "change irq");
        chk({7'h0, o_wake}, {7'h0, master & i_sleep & anyf()}, "wake");
        chk({7'h0, o_irq}, {7'h0, |(stat & ev_en)}, "irq");
    endtask
    task automatic drive(input logic [7:0] a, b, c, e, input logic s);
        logic [7:0] nv [4];
        logic [7:0] ed;
        nv = '{a, b, c, e};
        @(posedge i_sys_clk);
        pins.set_levels(a, b, c, e);
        i_sleep <= s;
        for (int p = 0; p < 4; p++) begin
            ed = ((rise[p] & nv[p] & ~cur[p]) | (fall[p] & ~nv[p] & cur[p])) & msk(p);
            flag[p] = flag[p] | ed;
            if (ed != 8'h00) stat[p] = 1'b1;
            cur[p] = nv[p];
        end
        repeat (4) @(posedge i_sys_clk);
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        logic [7:0] seen;
        repeat (6) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        check_all();
        $display("test reset done");
        for (int a = 0; a < 12; a++) if (a % 3 != 2) mwr(a, 8'(xs()));
        check_all();
        $display("test enables done");
        for (int i = 0; i < 48; i++) begin
            if (i == 24) mwr(PCD_CTRL, 8'h01);
            if (i % 8 == 0) mwr(PCD_IRQ_EN, 8'(xs()));
            if (i % 8 == 4) mwr(PCD_IRQ_CLR, 8'(xs()));
            // software clears only the flags it has seen, leaving the rest written as one
            if (i % 4 == 3) for (int p = 0; p < 4; p++) begin
                seen = flag[p] & 8'(xs());
                mwr(3 * p + 2, flag[p] & ~seen);
            end
            drive(8'(xs()), 8'(xs()), 8'(xs()), 8'(xs()), xs() % 2 == 0);
            check_all();
        end
        $display("test random edges done");
        mwr(PCD_A_RISE, 8'h80);
        drive(cur[0] & 8'h7f, cur[1], cur[2], cur[3], 1'b0);
        @(posedge i_sys_clk);
        pins.set_levels(cur[0] | 8'h80, cur[1], cur[2], cur[3]);
        @(posedge i_sys_clk);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= PCD_A_FLAG;
        i_wdata <= 8'h00;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        cur[0] = cur[0] | 8'h80;
        flag[0] = 8'h80;
        stat[0] = 1'b1;
        repeat (2) @(posedge i_sys_clk);
        rd(PCD_A_FLAG, 8'h80);
        check_all();
        $display("test clear collision done");
        close_out();
    end
endmodule
